// ==== mccrf_pkg.sv ====
// constants and types for the channelized capture record formatter
package mccrf_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EXT_HI = 8'h04;
    localparam logic [7:0] ADDR_EXT_LO = 8'h08;
    localparam logic [7:0] ADDR_CONN_CFG = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_FRM_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CNT_LSB = 16;
    localparam logic [1:0] KIND_HDLC = 2'h0;
    localparam logic [1:0] KIND_RAW = 2'h1;
    localparam logic [1:0] KIND_ATM = 2'h2;
    localparam logic [1:0] LINE_T1 = 2'h0;
    localparam logic [1:0] LINE_E1 = 2'h1;
    localparam logic [1:0] LINE_E1F = 2'h2;
    localparam logic [6:0] chan_hdlc_record_type = 7'h05;
    localparam logic [6:0] chan_raw_slot_record_type = 7'h06;
    localparam logic [6:0] chan_atm_cell_record_type = 7'h07;
    localparam int FLG_VLEN_BIT = 2;
    localparam int FLG_RXERR_BIT = 4;
    localparam logic [15:0] REC_HDR_BYTES = 16'h0010;
    localparam logic [15:0] EXT_HDR_BYTES = 16'h0008;
    localparam logic [15:0] CHAN_HDR_BYTES = 16'h0004;
    localparam logic [15:0] PROTO_BYTES = 16'h0004;
    localparam logic [15:0] ATM_REC_BYTES = 16'h0048;
    localparam logic [12:0] ATM_PAY_BYTES = 13'h0030;
    localparam logic [4:0] T1_SLOTS = 5'h18;
    localparam logic [4:0] E1_SLOTS = 5'h1f;
    localparam logic [4:0] E1F_SLOTS = 5'h1e;
    localparam logic [12:0] HDLC_SHORT = 13'h0005;
    localparam logic [12:0] RAW_SHORT = 13'h0006;
    localparam logic [12:0] LONG_MAX = 13'h07ff;
    localparam int HB_FCS = 24;
    localparam int HB_SHORT = 25;
    localparam int HB_LONG = 26;
    localparam int HB_ABORT = 27;
    localparam int HB_OCTET = 28;
    localparam int HB_LOST = 29;
    localparam int HB_FIRST = 30;
    localparam int AB_IMA = 15;
    localparam int AB_PORT = 16;
    localparam int AB_LOST = 24;
    localparam int AB_HEC = 25;
    localparam int AB_OAM = 27;
    localparam int AB_FIRST = 28;
    localparam int N_CONN = 1024;
    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY} mccrf_state_type;
endpackage

// ==== mccrf_formatter.sv ====
// channelized capture record formatter with apb control
////////////////////////////////////////////////////////////////////////////////
module mccrf_formatter
    import mccrf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic rec_start,
    input wire logic [1:0] rec_kind,
    input wire logic [9:0] rec_conn,
    input wire logic [3:0] rec_port,
    input wire logic [11:0] rec_len,
    input wire logic [63:0] rec_ts,
    input wire logic [31:0] rec_proto,
    input wire logic rec_fcs_err,
    input wire logic rec_abort_err,
    input wire logic rec_octet_err,
    input wire logic rec_lost_byte,
    input wire logic rec_hec_fixed,
    input wire logic rec_oam_cell,
    input wire logic rec_ima_group,
    output logic rec_ready,
    input wire logic pay_valid,
    input wire logic [7:0] pay_data,
    input wire logic [4:0] pay_slot,
    output logic pay_ready,
    output logic out_valid,
    output logic [31:0] out_data,
    output logic out_last,
    input wire logic out_ready
);
    typedef struct packed {
        mccrf_state_type st;
        logic [2:0] step;
        logic [1:0] kind;
        logic ext;
        logic [9:0] conn;
        logic [3:0] port;
        logic [6:0] errs;
        logic first;
        logic [31:0] proto;
        logic [63:0] ts;
        logic [12:0] plen;
        logic [12:0] left;
        logic [31:0] pack;
        logic [1:0] pcnt;
        logic full;
        logic out_valid;
        logic [31:0] out_data;
        logic out_last;
        logic pay_ready;
        logic rec_ready;
        logic [31:0] ctrl;
        logic [31:0] ext_hi;
        logic [31:0] ext_lo;
        logic [N_CONN-1:0] fresh;
        logic [15:0] nrec;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } mccrf_reg_type;

    mccrf_reg_type r_reg;
    mccrf_reg_type r_next;
    logic free;
    logic [9:0] idx;
    logic cfg_wr;
    logic apb_done;

    ////////////////////////////////////////////////////////////////////////////
    // errs: fcs, abort, octet, lost, hec, oam, ima
    function automatic logic [31:0] chan_hdr(input mccrf_reg_type s);
        logic [31:0] h;
        h = 32'h0;
        unique case (s.kind)
            KIND_RAW:
            begin
                h[3:0] = s.port;
                h[HB_SHORT] = s.plen < RAW_SHORT;
                h[HB_LONG] = s.plen > LONG_MAX;
                h[HB_LOST] = s.errs[3];
                h[HB_FIRST] = s.first;
            end
            KIND_ATM:
            begin
                h[9:0] = s.errs[0] ? {1'b0, s.conn[8:0]} : s.conn;
                h[AB_IMA] = s.errs[0];
                h[AB_PORT +: 4] = s.port;
                h[AB_LOST] = s.errs[3];
                h[AB_HEC] = s.errs[2];
                h[AB_OAM] = s.errs[1];
                h[AB_FIRST] = s.first;
            end
            default:
            begin
                h[9:0] = s.conn;
                h[HB_FCS] = s.errs[6];
                h[HB_SHORT] = s.plen < HDLC_SHORT;
                h[HB_LONG] = s.plen > LONG_MAX;
                h[HB_ABORT] = s.errs[5];
                h[HB_OCTET] = s.errs[4];
                h[HB_LOST] = s.errs[3];
                h[HB_FIRST] = s.first;
            end
        endcase
        return h;
    endfunction

    // hec correction is a repair, not an error, so only lost byte counts
    function automatic logic rx_err(input mccrf_reg_type s);
        logic [31:0] h;
        h = chan_hdr(s);
        return (s.kind == KIND_ATM) ? h[AB_LOST] : |h[HB_LOST:HB_FCS];
    endfunction

    function automatic logic [15:0] rec_bytes(input mccrf_reg_type s);
        logic [15:0] n;
        n = REC_HDR_BYTES + CHAN_HDR_BYTES;
        if (s.ext)
            n = n + EXT_HDR_BYTES;
        if (s.kind != KIND_RAW)
            n = n + PROTO_BYTES;
        n = n + (({3'h0, s.plen} + 16'h0003) & 16'hfffc);
        return n;
    endfunction

    function automatic logic [31:0] hdr_word(input mccrf_reg_type s);
        logic [6:0] t;
        logic [7:0] f;
        t = (s.kind == KIND_RAW) ? chan_raw_slot_record_type :
            (s.kind == KIND_ATM) ? chan_atm_cell_record_type :
            chan_hdlc_record_type;
        f = 8'h00;
        f[FLG_VLEN_BIT] = 1'b1;
        f[FLG_RXERR_BIT] = rx_err(s);
        unique case (s.step)
            3'h0: hdr_word = s.ts[63:32];
            3'h1: hdr_word = s.ts[31:0];
            3'h2: hdr_word = {s.ext, t, f, rec_bytes(s)};
            3'h3: hdr_word = {(s.kind == KIND_HDLC) ? {12'h0, s.port} : 16'h0,
                              3'h0, s.plen};
            3'h4: hdr_word = s.ext_hi;
            3'h5: hdr_word = s.ext_lo;
            3'h6: hdr_word = chan_hdr(s);
            default: hdr_word = s.proto;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign free = !r_reg.out_valid || out_ready;
    assign idx = (rec_kind == KIND_RAW) ? {6'h0, rec_port} : rec_conn;
    assign apb_done = psel && penable && r_reg.pready;
    assign cfg_wr = apb_done && pwrite && paddr == ADDR_CONN_CFG;

    always_comb
    begin
        logic [4:0] slots;
        logic last_hdr;
        r_next = r_reg;
        slots = T1_SLOTS;
        last_hdr = 1'b0;
        if (r_reg.out_valid && out_ready)
            r_next.out_valid = 1'b0;
        r_next.pready = psel && penable && !r_reg.pready;
        r_next.pslverr = 1'b0;
        r_next.prdata = 32'h0;
        if (psel && penable && !r_reg.pready)
        begin
            unique case (paddr)
                ADDR_CTRL: r_next.prdata = r_reg.ctrl;
                ADDR_EXT_HI: r_next.prdata = r_reg.ext_hi;
                ADDR_EXT_LO: r_next.prdata = r_reg.ext_lo;
                ADDR_CONN_CFG: r_next.prdata = 32'h0;
                ADDR_STATUS:
                begin
                    r_next.prdata[STAT_BUSY_BIT] = r_reg.st != ST_IDLE;
                    r_next.prdata[STAT_CNT_LSB +: 16] = r_reg.nrec;
                end
                default: r_next.pslverr = 1'b1;
            endcase
        end
        if (apb_done && pwrite)
        begin
            if (paddr == ADDR_CTRL)
                r_next.ctrl = pwdata;
            if (paddr == ADDR_EXT_HI)
                r_next.ext_hi = pwdata;
            if (paddr == ADDR_EXT_LO)
                r_next.ext_lo = pwdata;
        end
        unique case (r_reg.st)
            ST_IDLE:
            begin
                if (rec_start && r_reg.rec_ready)
                begin
                    r_next.st = ST_HDR;
                    r_next.step = 3'h0;
                    r_next.kind = rec_kind;
                    r_next.ext = r_reg.ctrl[CTRL_EXT_BIT];
                    r_next.conn = rec_conn;
                    r_next.port = rec_port;
                    r_next.errs = {rec_fcs_err, rec_abort_err, rec_octet_err,
                                   rec_lost_byte, rec_hec_fixed, rec_oam_cell,
                                   rec_ima_group};
                    r_next.proto = rec_proto;
                    r_next.ts = rec_ts;
                    r_next.first = r_reg.fresh[idx];
                    r_next.fresh[idx] = 1'b0;
                    if (r_reg.ctrl[CTRL_MODE_LSB +: 2] == LINE_E1)
                        slots = E1_SLOTS;
                    else if (r_reg.ctrl[CTRL_MODE_LSB +: 2] == LINE_E1F)
                        slots = E1F_SLOTS;
                    if (rec_kind == KIND_RAW)
                        r_next.plen = {5'h0, r_reg.ctrl[CTRL_FRM_LSB +: 8]} * {8'h0, slots};
                    else if (rec_kind == KIND_ATM)
                        r_next.plen = ATM_PAY_BYTES;
                    else
                        r_next.plen = {1'b0, rec_len};
                    r_next.left = r_next.plen;
                    r_next.pack = 32'h0;
                    r_next.pcnt = 2'h0;
                    r_next.full = 1'b0;
                end
            end
            ST_HDR:
            begin
                if (free)
                begin
                    last_hdr = r_reg.step == 3'h7 ||
                               (r_reg.step == 3'h6 && r_reg.kind == KIND_RAW);
                    r_next.out_valid = 1'b1;
                    r_next.out_data = hdr_word(r_reg);
                    r_next.out_last = last_hdr && r_reg.plen == 13'h0;
                    if (r_reg.step == 3'h3 && !r_reg.ext)
                        r_next.step = 3'h6;
                    else
                        r_next.step = r_reg.step + 3'h1;
                    if (last_hdr)
                    begin
                        r_next.st = (r_reg.plen == 13'h0) ? ST_IDLE : ST_PAY;
                        if (r_reg.plen == 13'h0)
                            r_next.nrec = r_reg.nrec + 16'h1;
                    end
                end
            end
            ST_PAY:
            begin
                if (r_reg.full && free)
                begin
                    r_next.out_valid = 1'b1;
                    r_next.out_data = r_reg.pack;
                    r_next.out_last = r_reg.left == 13'h0;
                    r_next.full = 1'b0;
                    r_next.pack = 32'h0; // zero padding to the word
                    r_next.pcnt = 2'h0;
                    if (r_reg.left == 13'h0)
                    begin
                        r_next.st = ST_IDLE;
                        r_next.nrec = r_reg.nrec + 16'h1;
                    end
                end
                else if (pay_valid && r_reg.pay_ready)
                begin
                    // the framing slot is consumed but never stored
                    if (!(r_reg.kind == KIND_RAW && pay_slot == 5'h0 &&
                          r_reg.ctrl[CTRL_MODE_LSB +: 2] == LINE_E1F))
                    begin
                        r_next.pack[8 * (3 - r_reg.pcnt) +: 8] = pay_data;
                        r_next.pcnt = r_reg.pcnt + 2'h1;
                        r_next.left = r_reg.left - 13'h1;
                        r_next.full = r_reg.pcnt == 2'h3 || r_reg.left == 13'h1;
                    end
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
        if (cfg_wr)
            r_next.fresh[pwdata[9:0]] = 1'b1; // configure wins over a same-cycle clear
        r_next.pay_ready = r_next.st == ST_PAY && !r_next.full && r_next.left != 13'h0;
        r_next.rec_ready = r_next.st == ST_IDLE && r_next.ctrl[CTRL_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg <= '0;
            r_reg.ctrl <= CTRL_RESET;
            r_reg.fresh <= '1;
        end
        else
            r_reg <= r_next;
    end

    assign pready = r_reg.pready;
    assign prdata = r_reg.prdata;
    assign pslverr = r_reg.pslverr;
    assign rec_ready = r_reg.rec_ready;
    assign pay_ready = r_reg.pay_ready;
    assign out_valid = r_reg.out_valid;
    assign out_data = r_reg.out_data;
    assign out_last = r_reg.out_last;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic w2_rxerr_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            w2_rxerr_reg <= 1'b0;
        else if (r_reg.st == ST_HDR && r_reg.step == 3'h2 && free)
            w2_rxerr_reg <= r_next.out_data[16 + FLG_RXERR_BIT];
    end

    sequence s_load(int k);
        r_reg.st == ST_HDR && free && r_reg.step == k;
    endsequence
    sequence s_accept;
        r_reg.st == ST_IDLE && rec_start && r_reg.rec_ready;
    endsequence

    type_raw_a: assert property (s_load(2) and r_reg.kind == KIND_RAW |=>
        out_data[30:24] == 7'h06) else $error("raw record type code wrong");
    type_atm_a: assert property (s_load(2) and r_reg.kind == KIND_ATM |=>
        out_data[30:24] == 7'h07) else $error("atm record type code wrong");
    // ext is held for the whole record, so the bit must match it in both senses
    ext_bit_a: assert property (s_load(2) |=> out_data[31] == r_reg.ext)
        else $error("extension bit wrong");
    ext_word_a: assert property (s_load(4) |=> out_data == $past(r_reg.ext_hi))
        else $error("extension header word wrong");
    flag_iface_a: assert property (s_load(2) |=>
        out_data[17:16] == 2'h0 && out_data[18]) else $error("flags byte wrong");
    rx_err_a: assert property (s_load(6) |=>
        w2_rxerr_reg == ((r_reg.kind == KIND_ATM) ? out_data[24] : |out_data[29:24]))
        else $error("rx error flag disagrees with channel header");
    atm_len_a: assert property (s_load(2) and r_reg.kind == KIND_ATM |=>
        out_data[15:0] == 16'h0048) else $error("atm record not 72 bytes");
    atm_pay_a: assert property (s_accept and rec_kind == KIND_ATM |=>
        r_reg.plen == 13'h030 ##1 r_reg.st == ST_HDR) else $error("atm payload not 48");
    t1_len_a: assert property (s_accept and rec_kind == KIND_RAW and
        r_reg.ctrl[3:2] == 2'h0 |=> r_reg.plen == 13'(24 * $past(r_reg.ctrl[15:8])))
        else $error("t1 payload size wrong");
    e1f_drop_a: assert property (r_reg.st == ST_PAY && r_reg.kind == KIND_RAW &&
        r_reg.ctrl[3:2] == 2'h2 && pay_valid && pay_ready && pay_slot == 5'h0 &&
        !r_reg.full |=> $stable(r_reg.left)) else $error("framing slot stored");
    first_clr_a: assert property (s_accept and !cfg_wr |=>
        !r_reg.fresh[$past(idx)]) else $error("first flag not cleared");
    hdlc_len_a: assert property (s_load(2) and r_reg.kind == KIND_HDLC |=>
        out_data[15:0] >= 16'h0018) else $error("hdlc rlen below header sizes");
endmodule

// ==== mccrf_host_sink.sv ====
// host memory sink model: takes record words, optionally stalling
module mccrf_host_sink
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic out_last,
    output logic out_ready,
    output logic [15:0] rec_words
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] stall_cnt;

    // slow mode opens only one cycle in three so words back up at the source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stall_cnt <= 2'h0;
            out_ready <= 1'b0;
            rec_words <= 16'h0;
        end
        else
        begin
            stall_cnt <= (stall_cnt == 2'h2) ? 2'h0 : stall_cnt + 2'h1;
            out_ready <= !slow || (stall_cnt == 2'h2);
            // next record begins right after the last word, so count words per record
            if (out_valid && out_ready)
                rec_words <= out_last ? 16'h0 : rec_words + 16'h1;
        end
    end
endmodule

// ==== testbench.sv ====
// self-checking bench for the channelized capture record formatter
module testbench
    import mccrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] d; logic [31:0] m; logic l; logic [15:0] rlen;} mccrf_exp_type;
    localparam logic [31:0] EXT_A = 32'h8a3c_0101;
    localparam logic [31:0] EXT_B = 32'h0f1e_2d3c;
    mccrf_exp_type exp_q[$];
    mccrf_exp_type e;
    int seed = 27;
    int bad_count = 0;
    int n_compared = 0;
    int slots[3] = '{24, 31, 30};
    logic [1:0] lines[3] = '{LINE_T1, LINE_E1, LINE_E1F};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00, pay_data = 8'h00;
    logic [31:0] pwdata = 32'h0, rec_proto = 32'h0;
    logic rec_start = 1'b0, pay_valid = 1'b0;
    logic [1:0] rec_kind = 2'h0;
    logic [9:0] rec_conn = 10'h0;
    logic [3:0] rec_port = 4'h0;
    logic [11:0] rec_len = 12'h0;
    logic [63:0] rec_ts = 64'h0;
    logic [4:0] pay_slot = 5'h0;
    logic rec_fcs_err = 1'b0, rec_abort_err = 1'b0, rec_octet_err = 1'b0, rec_lost_byte = 1'b0;
    logic rec_hec_fixed = 1'b0, rec_oam_cell = 1'b0, rec_ima_group = 1'b0;
    logic pready, pslverr, rec_ready, pay_ready, out_valid, out_last, out_ready;
    logic [31:0] prdata, out_data;
    logic [15:0] rec_words;

    mccrf_formatter u_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rec_start(rec_start), .rec_kind(rec_kind), .rec_conn(rec_conn), .rec_port(rec_port),
        .rec_len(rec_len), .rec_ts(rec_ts), .rec_proto(rec_proto), .rec_fcs_err(rec_fcs_err),
        .rec_abort_err(rec_abort_err), .rec_octet_err(rec_octet_err),
        .rec_lost_byte(rec_lost_byte), .rec_hec_fixed(rec_hec_fixed),
        .rec_oam_cell(rec_oam_cell), .rec_ima_group(rec_ima_group), .rec_ready(rec_ready),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_slot(pay_slot), .pay_ready(pay_ready),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready)
    );

    mccrf_host_sink u_host
    (
        .pclk(pclk), .presetn(presetn), .slow(slow), .out_valid(out_valid),
        .out_last(out_last), .out_ready(out_ready), .rec_words(rec_words)
    );

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [31:0] ctrl_w(input logic [1:0] ln, input logic ext);
        return {16'h0, 8'h01, 4'h0, ln, ext, 1'b1};
    endfunction

    task automatic push(input logic [31:0] d, input logic [31:0] m, input logic l,
                        input logic [15:0] rlen);
        exp_q.push_back('{d, m, l, rlen});
    endtask

    // no own limit: a stuck record is caught by the watchdog
    task automatic drain();
        while (exp_q.size() > 0)
            @(posedge pclk);
        @(posedge pclk);
    endtask

    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic [31:0] msk, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        if (!wr)
            check(prdata & msk, exp);
        check({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // err bits: 0 fcs, 1 abort, 2 octet, 3 lost, 4 hec, 5 oam, 6 ima
    task automatic run_rec(input logic [1:0] kind, input logic [9:0] conn,
                           input logic [3:0] port, input int n, input logic [6:0] err,
                           input logic first, input logic ext_on, input logic skip0);
        logic [63:0] ts;
        logic [31:0] ch, pr, w;
        logic [15:0] rlen;
        logic [6:0] typ;
        logic rx;
        logic [7:0] b[$];
        int i, k;
        ts = {$random(seed), $random(seed)};
        pr = $random(seed);
        rlen = 16'(20 + (ext_on ? 8 : 0) + ((kind != KIND_RAW) ? 4 : 0) +
                   4 * ((n + 3) / 4));
        case (kind)
            KIND_HDLC:
            begin
                typ = chan_hdlc_record_type;
                ch = {1'b0, first, err[3:1], 1'b0, (n < 5), err[0], 14'h0, conn};
                rx = |ch[29:24];
            end
            KIND_RAW:
            begin
                typ = chan_raw_slot_record_type;
                ch = {1'b0, first, err[3], 3'h0, (n < 6), 21'h0, port};
                rx = ch[29] | ch[25];
            end
            default:
            begin
                typ = chan_atm_cell_record_type;
                // ima: only the low 9 bits carry the group id, bit 9 stays clear
                ch = {3'h0, first, err[5], 1'b0, err[4], err[3], 4'h0, port, err[6], 5'h0,
                      err[6] ? {1'b0, conn[8:0]} : conn};
                rx = err[3];
            end
        endcase
        push(ts[63:32], 32'hffffffff, 1'b0, rlen);
        push(ts[31:0], 32'hffffffff, 1'b0, rlen);
        push({ext_on, typ, 3'h0, rx, 1'b0, 1'b1, 2'h0, rlen},
             32'hffffffff, 1'b0, rlen);
        push({12'h0, (kind == KIND_HDLC) ? port : 4'h0, 16'(n)},
             (kind == KIND_HDLC) ? 32'hffffffff : 32'h0000ffff, 1'b0, rlen);
        if (ext_on)
        begin
            push(EXT_A, 32'hffffffff, 1'b0, rlen);
            push(EXT_B, 32'hffffffff, 1'b0, rlen);
        end
        push(ch, 32'hffffffff, 1'b0, rlen);
        if (kind != KIND_RAW)
            push(pr, 32'hffffffff, 1'b0, rlen);
        for (i = 0; i < n; i++)
            b.push_back(8'($random(seed)));
        for (i = 0; i < n; i += 4)
        begin
            w = 32'h0;
            for (k = 0; k < 4 && i + k < n; k++)
                w[31 - 8 * k -: 8] = b[i + k];
            push(w, 32'hffffffff, (i + 4 >= n), rlen);
        end
        // framing slot byte goes in first and must never reach the record
        if (skip0)
            b.push_front(8'h5a);
        @(posedge pclk);
        rec_kind <= kind;
        rec_conn <= conn;
        rec_port <= port;
        rec_len <= 12'(n);
        rec_ts <= ts;
        rec_proto <= pr;
        {rec_ima_group, rec_oam_cell, rec_hec_fixed, rec_lost_byte} <= err[6:3];
        {rec_octet_err, rec_abort_err, rec_fcs_err} <= err[2:0];
        rec_start <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (rec_ready !== 1'b1);
        rec_start <= 1'b0;
        for (i = 0; i < b.size(); i++)
        begin
            pay_valid <= 1'b1;
            pay_data <= b[i];
            pay_slot <= 5'(i);
            do
            begin
                @(posedge pclk);
            end
            while (pay_ready !== 1'b1);
        end
        pay_valid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        if (presetn && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                bad_count++;
                $display("ERROR t=%0t seen=%h exp=none", $time, out_data);
            end
            else
            begin
                e = exp_q.pop_front();
                check(out_data & e.m, e.d & e.m);
                check({31'h0, out_last}, {31'h0, e.l});
                if (e.l)
                    check({14'h0, rec_words + 16'h1, 2'h0}, {16'h0, e.rlen});
            end
        end
    end

    initial
    begin
        #500us;
        bad_count++;
        end_sim();
    end

    initial
    begin
        int i;
        logic [9:0] conn_a;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0, CTRL_RESET, 32'hffffffff, 1'b0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 8'h44, 32'h1, 32'h0, 32'h0, 1'b1);
        for (i = 0; i < 3; i++)
        begin
            drain();
            apb(1'b1, ADDR_CTRL, ctrl_w(lines[i], 1'b0), 32'h0, 32'h0, 1'b0);
            if (i == 2)
                apb(1'b1, ADDR_CONN_CFG, 32'h3, 32'h0, 32'h0, 1'b0);
            slow <= (i == 1);
            run_rec(KIND_RAW, 10'h0, 4'h3, slots[i], (i == 1) ? 7'h08 : 7'h00,
                    (i != 1), 1'b0, (i == 2));
        end
        apb(1'b0, ADDR_CTRL, 32'h0, ctrl_w(LINE_E1F, 1'b0), 32'hffffffff, 1'b0);
        conn_a = 10'h200 | 10'($random(seed) & 32'hff);
        for (i = 0; i < 2; i++)
            run_rec(KIND_ATM, conn_a, 4'(i + 9), 48, (i == 0) ? 7'h48 : 7'h30,
                    (i == 0), 1'b0, 1'b0);
        drain();
        apb(1'b1, ADDR_EXT_HI, EXT_A, 32'h0, 32'h0, 1'b0);
        apb(1'b1, ADDR_EXT_LO, EXT_B, 32'h0, 32'h0, 1'b0);
        apb(1'b1, ADDR_CTRL, ctrl_w(LINE_T1, 1'b1), 32'h0, 32'h0, 1'b0);
        run_rec(KIND_HDLC, 10'h155, 4'h2, 3, 7'h05, 1'b1, 1'b1, 1'b0);
        drain();
        apb(1'b0, ADDR_STATUS, 32'h0, 32'h0006_0000, 32'hffff_0001, 1'b0);
        end_sim();
    end
endmodule
